// [include/ptws_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE1] postscaler divides matches 1:1 to 1:16
// [RULE2] prescaler divides clock by 1, 4 or 16
// [RULE3] timer advances only while run bit set
// [RULE4] control at 12h, bit 7 zero, resets zero
// [RULE5] count register at 11h, resets to zero
// [RULE6] period register at 92h, resets to ones
// [RULE7] match flag in 0Ch bit 1, bit 3 unused
// [RULE8] match enable in 8Ch bit 1, bit 3 unused
// [RULE9] interrupt control mirrored four times, bit 0 kept
// [RULE10] count wraps after equal, emits match event
// [RULE11] postscaled match sets flag, software writes zero
//////////////////////////////////////////////////////////////////////////////
package ptws_pkg;

    localparam int unsigned HADDR_W = 12;
    localparam int unsigned IDX_W   = 10;
    localparam int unsigned DATA_W  = 8;

    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_INTCTL_0 = 10'h00B;
    localparam logic [IDX_W-1:0] IDX_INTCTL_1 = 10'h08B;
    localparam logic [IDX_W-1:0] IDX_INTCTL_2 = 10'h10B;
    localparam logic [IDX_W-1:0] IDX_INTCTL_3 = 10'h18B;
    localparam logic [IDX_W-1:0] IDX_FLAGS    = 10'h00C;
    localparam logic [IDX_W-1:0] IDX_COUNT    = 10'h011;
    localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h012;
    localparam logic [IDX_W-1:0] IDX_ENABLES  = 10'h08C;
    localparam logic [IDX_W-1:0] IDX_MATCH    = 10'h092;
    localparam logic [IDX_W-1:0] IDX_EVT_STAT = 10'h020;
    localparam logic [IDX_W-1:0] IDX_EVT_CLR  = 10'h021;
    localparam logic [IDX_W-1:0] IDX_EVT_EN   = 10'h022;
    localparam logic [1:0]       BYTE_LSB     = 2'h0;

    // reset values and masks
    localparam logic [7:0] COUNT_RST   = 8'h00;
    localparam logic [7:0] MATCH_RST   = 8'hFF;
    localparam logic [6:0] CTRL_RST    = 7'h00;
    localparam logic [7:0] FLAGS_RST   = 8'h00;
    localparam logic [7:0] ENABLES_RST = 8'h00;
    localparam logic [6:0] INTCTL_RST  = 7'h00;
    localparam logic [7:0] PERIPH_MASK = 8'hF7;

    // field positions
    localparam int unsigned MATCH_BIT = 1;
    localparam int unsigned GIE_BIT   = 7;
    localparam int unsigned PERIPHERAL_IRQ_GATE_BIT  = 6;

    // prescaler encodings and terminal counts
    localparam logic [1:0] PRE_DIV1   = 2'h0;
    localparam logic [1:0] PRE_DIV4   = 2'h1;
    localparam int unsigned PRE_W     = 4;
    localparam logic [3:0] PRE_LIM_1  = 4'h0;
    localparam logic [3:0] PRE_LIM_4  = 4'h3;
    localparam logic [3:0] PRE_LIM_16 = 4'hF;

    // event status bits
    localparam int unsigned EVT_W    = 2;
    localparam int unsigned EVT_POST = 0;
    localparam int unsigned EVT_RAW  = 1;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic       unused;
        logic [3:0] post_sel;
        logic       run;
        logic [1:0] pre_sel;
    } ptws_ctrl_t;

    typedef struct packed {
        logic               valid;
        logic               write;
        logic [HADDR_W-1:0] addr;
    } ptws_aphase_t;

    function automatic logic reg_hit(input logic [HADDR_W-1:0] a,
                                     input logic [IDX_W-1:0]   idx);
        reg_hit = (a == {idx, BYTE_LSB});
    endfunction

endpackage

// [rtl/ptws_scaler.sv]
`timescale 1ns/10ps
module ptws_scaler
    import ptws_pkg::*;
#(
    parameter int unsigned W = 4
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_n_i,
    input  wire logic         clr_i,
    input  wire logic         ev_i,
    input  wire logic [W-1:0] limit_i,
    output logic              done_o
);

    logic [W-1:0] cnt_ff;
    logic         at_limit;

    // greater-or-equal catches a limit lowered below the running count
    assign at_limit = (cnt_ff >= limit_i);
    assign done_o   = ev_i & at_limit;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || clr_i) begin
            cnt_ff <= '0;
        end else if (ev_i) begin
            if (at_limit) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + W'(1);
            end
        end
    end

endmodule // ptws_scaler

// [rtl/ptws_timer.sv]
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
module ptws_timer
    import ptws_pkg::*;
#(
    parameter int unsigned CNT_W = DATA_W
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    // ahb-lite slave
    input  wire logic                 hsel_i,
    input  wire logic [HADDR_W-1:0]   haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    output logic [31:0]               hrdata_o,
    // interrupts
    output logic                      irq_o,
    output logic                      core_irq_req_o,
    output logic                      match_pulse_o
);

    //////////////////////////////////////////////////////////////////////////
    // register storage

    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] match_ff;
    ptws_ctrl_t       ctrl_ff;
    logic [7:0]       flags_ff;
    logic [7:0]       enables_ff;
    logic [7:1]       intctl_hi_ff;
    logic             intctl_lo_ff;
    logic [EVT_W-1:0] evt_stat_ff;
    logic [EVT_W-1:0] evt_en_ff;
    logic             match_pulse_ff;
    logic [31:0]      rdata_ff;
    ptws_aphase_t     aph_ff;

    //////////////////////////////////////////////////////////////////////////
    // bus address phase

    ptws_aphase_t nxt_aph;
    logic         wr_go;
    logic [7:0]   wdata;

    always_comb begin
        nxt_aph.valid = hsel_i & hready_i & htrans_i[1];
        nxt_aph.write = hwrite_i;
        nxt_aph.addr  = haddr_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            aph_ff <= '0;
        end else if (hready_i) begin
            aph_ff <= nxt_aph;
        end
    end

    assign wr_go = aph_ff.valid & aph_ff.write;
    assign wdata = hwdata_i[7:0];

    function automatic logic wr_hit(input logic [IDX_W-1:0] idx);
        wr_hit = wr_go & reg_hit(aph_ff.addr, idx);
    endfunction

    logic wr_count;
    logic wr_match;
    logic wr_ctrl;
    logic wr_flags;
    logic wr_enables;
    logic wr_intctl;
    logic wr_evt_clr;
    logic wr_evt_en;

    assign wr_count   = wr_hit(IDX_COUNT);
    assign wr_match   = wr_hit(IDX_MATCH);
    assign wr_ctrl    = wr_hit(IDX_CTRL);
    assign wr_flags   = wr_hit(IDX_FLAGS);
    assign wr_enables = wr_hit(IDX_ENABLES);
    assign wr_evt_clr = wr_hit(IDX_EVT_CLR);
    assign wr_evt_en  = wr_hit(IDX_EVT_EN);
    assign wr_intctl  = wr_hit(IDX_INTCTL_0) | wr_hit(IDX_INTCTL_1) |
                        wr_hit(IDX_INTCTL_2) | wr_hit(IDX_INTCTL_3);     // [RULE9]

    //////////////////////////////////////////////////////////////////////////
    // prescaler

    logic [PRE_W-1:0] pre_limit;
    logic             tick;

    always_comb begin
        unique case (ctrl_ff.pre_sel)
            PRE_DIV1: pre_limit = PRE_LIM_1;                            // [RULE2]
            PRE_DIV4: pre_limit = PRE_LIM_4;                            // [RULE2]
            default:  pre_limit = PRE_LIM_16;                           // [RULE2]
        endcase
    end

    // writes to count or control restart the division
    ptws_scaler #(
        .W (PRE_W)
    ) u_prescale (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .clr_i     (wr_count | wr_ctrl),
        .ev_i      (ctrl_ff.run),                                       // [RULE3]
        .limit_i   (pre_limit),
        .done_o    (tick)
    );

    //////////////////////////////////////////////////////////////////////////
    // period counter

    logic raw_match;

    assign raw_match = tick & (count_ff == match_ff);                   // [RULE10]

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            count_ff <= CNT_W'(COUNT_RST);                              // [RULE5]
        end else if (wr_count) begin
            count_ff <= CNT_W'(wdata);                                  // [RULE5]
        end else if (raw_match) begin
            count_ff <= '0;                                             // [RULE10]
        end else if (tick) begin
            count_ff <= count_ff + CNT_W'(1);                           // [RULE10]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            match_ff <= CNT_W'(MATCH_RST);                              // [RULE6]
        end else if (wr_match) begin
            match_ff <= CNT_W'(wdata);                                  // [RULE6]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // postscaler

    logic post_done;

    ptws_scaler #(
        .W (4)
    ) u_postscale (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .clr_i     (wr_count | wr_ctrl),
        .ev_i      (raw_match),                                         // [RULE11]
        .limit_i   (ctrl_ff.post_sel),                                  // [RULE1]
        .done_o    (post_done)
    );

    //////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl_ff <= ptws_ctrl_t'({1'b0, CTRL_RST});                  // [RULE4]
        end else if (wr_ctrl) begin
            ctrl_ff <= ptws_ctrl_t'({1'b0, wdata[6:0]});                // [RULE4]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // peripheral flags and enables

    logic [7:0] nxt_flags;

    always_comb begin
        nxt_flags = flags_ff;
        if (wr_flags) begin
            nxt_flags = wdata & PERIPH_MASK;                            // [RULE7]
        end
        // hardware set wins over a same-cycle software clear
        if (post_done) begin
            nxt_flags[MATCH_BIT] = 1'b1;                                // [RULE11]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flags_ff <= FLAGS_RST;                                      // [RULE7]
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            enables_ff <= ENABLES_RST;                                  // [RULE8]
        end else if (wr_enables) begin
            enables_ff <= wdata & PERIPH_MASK;                          // [RULE8]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // global interrupt control

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            intctl_hi_ff <= INTCTL_RST;                                 // [RULE9]
        end else if (wr_intctl) begin
            intctl_hi_ff <= wdata[7:1];
        end
    end

    // bit 0 deliberately has no reset: it keeps its value across resets
    always_ff @(posedge clk_sys_i) begin
        if (wr_intctl) begin
            intctl_lo_ff <= wdata[0];                                   // [RULE9]
        end
    end

    assign core_irq_req_o = intctl_hi_ff[GIE_BIT] & intctl_hi_ff[PERIPHERAL_IRQ_GATE_BIT] &
                            flags_ff[MATCH_BIT] & enables_ff[MATCH_BIT]; // [RULE8]

    //////////////////////////////////////////////////////////////////////////
    // sticky event status, clear and enable

    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;

    always_comb begin
        evt_set           = '0;
        evt_set[EVT_POST] = post_done;
        evt_set[EVT_RAW]  = raw_match;
        evt_clr           = wr_evt_clr ? wdata[EVT_W-1:0] : '0;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            evt_stat_ff <= EVT_RST;
        end else begin
            evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            evt_en_ff <= EVT_RST;
        end else if (wr_evt_en) begin
            evt_en_ff <= wdata[EVT_W-1:0];
        end
    end

    assign irq_o = |(evt_stat_ff & evt_en_ff);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            match_pulse_ff <= 1'b0;
        end else begin
            match_pulse_ff <= raw_match;
        end
    end

    assign match_pulse_o = match_pulse_ff;

    //////////////////////////////////////////////////////////////////////////
    // read data, sampled in the address phase

    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = '0;
        if (reg_hit(haddr_i, IDX_COUNT)) begin
            rd_byte = 8'(count_ff);                                     // [RULE5]
        end else if (reg_hit(haddr_i, IDX_MATCH)) begin
            rd_byte = 8'(match_ff);                                     // [RULE6]
        end else if (reg_hit(haddr_i, IDX_CTRL)) begin
            rd_byte = {1'b0, ctrl_ff[6:0]};                             // [RULE4]
        end else if (reg_hit(haddr_i, IDX_FLAGS)) begin
            rd_byte = flags_ff & PERIPH_MASK;                           // [RULE7]
        end else if (reg_hit(haddr_i, IDX_ENABLES)) begin
            rd_byte = enables_ff & PERIPH_MASK;                         // [RULE8]
        end else if (reg_hit(haddr_i, IDX_INTCTL_0) ||
                     reg_hit(haddr_i, IDX_INTCTL_1) ||
                     reg_hit(haddr_i, IDX_INTCTL_2) ||
                     reg_hit(haddr_i, IDX_INTCTL_3)) begin
            rd_byte = {intctl_hi_ff, intctl_lo_ff};                     // [RULE9]
        end else if (reg_hit(haddr_i, IDX_EVT_STAT)) begin
            rd_byte = 8'(evt_stat_ff);
        end else if (reg_hit(haddr_i, IDX_EVT_EN)) begin
            rd_byte = 8'(evt_en_ff);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_ff <= '0;
        end else if (nxt_aph.valid && !hwrite_i) begin
            rdata_ff <= {24'h000000, rd_byte};
        end
    end

    assign hrdata_o    = rdata_ff;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = HRESP_OKAY;

endmodule // ptws_timer

// [test/ptws_timer_checker.sv]
`timescale 1ns/10ps
module ptws_timer_checker
    import ptws_pkg::*;
(
    input wire logic               clk_sys_i,
    input wire logic               rst_n_i,
    input wire logic               hsel_i,
    input wire logic [HADDR_W-1:0] haddr_i,
    input wire logic [1:0]         htrans_i,
    input wire logic               hwrite_i,
    input wire logic [2:0]         hsize_i,
    input wire logic [31:0]        hwdata_i,
    input wire logic               hready_i,
    input wire logic               hreadyout_o,
    input wire logic               hresp_o,
    input wire logic [31:0]        hrdata_o,
    input wire logic               irq_o,
    input wire logic               core_irq_req_o,
    input wire logic               match_pulse_o
);
    logic             wr_ff;
    logic [IDX_W-1:0] idx_ff;
    logic [6:0]       ctrl_ff;
    logic [6:0]       ic_ff;
    logic [7:0]       en_ff;
    logic [7:0]       pm_ff;
    logic [1:0]       run_ff;
    logic             rd_take;
    logic             ic_rd;
    assign rd_take = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
    assign ic_rd = rd_take & ~haddr_i[11] & (haddr_i[8:0] == {IDX_INTCTL_0[6:0], BYTE_LSB});
    ////////////////////////////////////////
    // shadow of what software last wrote
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wr_ff <= 1'b0;
            idx_ff <= '0;
            run_ff <= 2'h0;
        end else begin
            wr_ff <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
            idx_ff <= haddr_i[HADDR_W-1:2];
            run_ff <= {run_ff[0], ctrl_ff[2]};
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl_ff <= CTRL_RST;
            ic_ff <= INTCTL_RST;
            en_ff <= ENABLES_RST;
            pm_ff <= MATCH_RST;
        end else if (wr_ff) begin
            if (idx_ff == IDX_CTRL) ctrl_ff <= hwdata_i[6:0];
            if (!idx_ff[9] && idx_ff[6:0] == IDX_INTCTL_0[6:0]) ic_ff <= hwdata_i[7:1];
            if (idx_ff == IDX_ENABLES) en_ff <= hwdata_i[7:0] & PERIPH_MASK;
            if (idx_ff == IDX_MATCH) pm_ff <= hwdata_i[7:0];
        end
    end
    ////////////////////////////////////////
    sequence rd_s(logic [IDX_W-1:0] idx);
        rd_take && haddr_i == {idx, BYTE_LSB};
    endsequence
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    hi_zero_a: assert property (hrdata_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    ctrl_rd_a: assert property (rd_s(IDX_CTRL) |=> hrdata_o[7:0] == {1'b0, $past(ctrl_ff)})
        else $error("control readback wrong");
    flag_b3_a: assert property (rd_s(IDX_FLAGS) |=> !hrdata_o[3])
        else $error("flag bit 3 not zero");
    en_rd_a: assert property (rd_s(IDX_ENABLES) |=> hrdata_o[7:0] == $past(en_ff))
        else $error("enable readback wrong");
    mirror_rd_a: assert property (ic_rd |=> hrdata_o[7:1] == $past(ic_ff))
        else $error("interrupt control mirror wrong");
    period_rd_a: assert property (rd_s(IDX_MATCH) |=> hrdata_o[7:0] == $past(pm_ff))
        else $error("period readback wrong");
    run_stop_a: assert property (!ctrl_ff[2] && run_ff == 2'h0 |-> !match_pulse_o)
        else $error("match while stopped");
    core_gate_a: assert property (core_irq_req_o |-> ic_ff[6] && ic_ff[5] && en_ff[1])
        else $error("core request not gated");
endmodule // ptws_timer_checker

bind ptws_timer ptws_timer_checker u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .irq_o(irq_o), .core_irq_req_o(core_irq_req_o),
    .match_pulse_o(match_pulse_o)
);

// [test/tb.sv]
`timescale 1ns/10ps
module tb
    import ptws_pkg::*;
;
    logic               clk_sys_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic               hsel_i = 1'b0;
    logic               hwrite_i = 1'b0;
    logic [1:0]         htrans_i = 2'h0;
    logic [HADDR_W-1:0] haddr_i = '0;
    logic [31:0]        hwdata_i = 32'h0;
    logic [31:0]        hrdata_o;
    logic [31:0]        rdat;
    logic               hreadyout_o, hresp_o, irq_o, core_irq_req_o, match_pulse_o;
    int                 failures = 0;
    int                 cmp_count = 0;
    int                 seed = 33285;
    int                 cyc = 0;
    logic [IDX_W-1:0]   idx_t [6] = '{IDX_CTRL, IDX_COUNT, IDX_MATCH, IDX_FLAGS, IDX_ENABLES,
                                      IDX_INTCTL_0};
    logic [7:0]         msk_t [6] = '{8'h7F, 8'hFF, 8'hFF, 8'hF7, 8'hF7, 8'hFF};
    ptws_timer dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .irq_o(irq_o), .core_irq_req_o(core_irq_req_o),
        .match_pulse_o(match_pulse_o)
    );
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    ////////////////////////////////////////
    task automatic end_of_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [IDX_W-1:0] idx, input logic [7:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {idx, BYTE_LSB};
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= {24'h000000, d};
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        rdat = hrdata_o;
    endtask
    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
    endtask
    task automatic wait_hi(input bit sel);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while ((sel ? irq_o : match_pulse_o) !== 1'b1 && n < 9000);
        if ((sel ? irq_o : match_pulse_o) !== 1'b1) failures++;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        failures++;
        end_of_test();
    end
    ////////////////////////////////////////
    initial begin : main
        int         i;
        int         t;
        int         p;
        int         dv;
        logic [3:0] post;
        logic [7:0] d;
        do_reset();
        for (i = 0; i < 6; i++) begin
            bus(1'b0, idx_t[i], 8'h00);
            chk("reset", (i == 2) ? 32'hFF : 32'h0, rdat & {24'hFFFFFF, (i == 5) ? 8'hFE : 8'hFF});
            chk("okay", 32'h0, {31'h0, hresp_o});
        end
        for (i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            if (i == 0) d = (d | 8'h80) & 8'hFB;
            bus(1'b1, idx_t[i], d);
            bus(1'b0, (i == 5) ? IDX_INTCTL_3 : idx_t[i], 8'h00);
            chk("readback", {24'h0, d & msk_t[i]}, rdat);
        end
        bus(1'b1, 10'h3FF, 8'hA5);
        bus(1'b0, 10'h3FF, 8'h00);
        chk("unmapped", 32'h0, rdat);
        bus(1'b1, IDX_COUNT, 8'h5A);
        repeat (40) @(posedge clk_sys_i);
        bus(1'b0, IDX_COUNT, 8'h00);
        chk("stopped count", 32'h5A, rdat);
        bus(1'b1, IDX_EVT_EN, 8'h01);
        bus(1'b1, IDX_ENABLES, 8'h00);
        for (i = 0; i < 4; i++) begin
            p = 8 + ($random(seed) & 7);
            post = (i == 3) ? 4'($random(seed)) : (i == 2) ? 4'hF : 4'(i);
            dv = (i == 0) ? 1 : (i == 1) ? 4 : 16;
            bus(1'b1, IDX_CTRL, 8'h00);
            bus(1'b1, IDX_COUNT, 8'h00);
            bus(1'b1, IDX_MATCH, 8'(p));
            bus(1'b1, IDX_FLAGS, 8'h00);
            bus(1'b1, IDX_CTRL, {1'b0, post, 1'b1, 2'(i)});
            wait_hi(1'b0);
            t = cyc;
            wait_hi(1'b0);
            chk("match spacing", 32'((p + 1) * dv), 32'(cyc - t));
            bus(1'b1, IDX_EVT_CLR, 8'h03);
            wait_hi(1'b1);
            t = cyc;
            bus(1'b0, IDX_FLAGS, 8'h00);
            chk("flag set", 32'h2, rdat & 32'h2);
            bus(1'b1, IDX_EVT_CLR, 8'h03);
            wait_hi(1'b1);
            chk("postscale spacing", 32'((p + 1) * dv * (post + 1)), 32'(cyc - t));
        end
        // stopped, flag still set from the last event
        bus(1'b1, IDX_CTRL, 8'h00);
        bus(1'b1, IDX_ENABLES, 8'h02);
        bus(1'b1, IDX_INTCTL_1, 8'hC0);
        @(posedge clk_sys_i);
        chk("core request", 32'h1, {31'h0, core_irq_req_o});
        bus(1'b1, IDX_INTCTL_1, 8'h80);
        @(posedge clk_sys_i);
        chk("core gated", 32'h0, {31'h0, core_irq_req_o});
        bus(1'b1, IDX_EVT_EN, 8'h00);
        @(posedge clk_sys_i);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        bus(1'b1, IDX_FLAGS, 8'h00);
        bus(1'b0, IDX_FLAGS, 8'h00);
        chk("flag clear", 32'h0, rdat);
        bus(1'b1, IDX_INTCTL_2, 8'hFF);
        do_reset();
        bus(1'b0, IDX_INTCTL_0, 8'h00);
        chk("control after reset", 32'h1, rdat);
        end_of_test();
    end
endmodule // tb
